// File: hdl/fisi_pkg.sv
package fisi_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses on APB)
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_STATUS    = 12'h000;
    localparam logic [11:0] OFS_CONFIG    = 12'h004;
    localparam logic [11:0] OFS_ERR_CFG   = 12'h008;
    localparam logic [11:0] OFS_ERR_STAT  = 12'h00c;
    localparam logic [11:0] OFS_SECURITY  = 12'h010;
    localparam logic [11:0] OFS_PPROT     = 12'h014;
    localparam logic [11:0] OFS_EPROT     = 12'h018;
    localparam logic [11:0] OFS_OPTION    = 12'h01c;
    localparam logic [11:0] OFS_CMD       = 12'h020;
    localparam logic [11:0] OFS_KEY01     = 12'h024;
    localparam logic [11:0] OFS_KEY23     = 12'h028;
    localparam logic [11:0] OFS_IRQ_STAT  = 12'h02c;
    localparam logic [11:0] OFS_IRQ_EN    = 12'h030;
    localparam logic [11:0] OFS_IRQ_CLR   = 12'h034;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_CMD_COMPLETE_FLAG      = 7;
    localparam int BIT_VERIFY1   = 1;
    localparam int BIT_VERIFY0   = 0;
    localparam int BIT_CMD_COMPLETE_IRQ_EN      = 7;
    localparam int BIT_SINGLE_FAULT_IRQ_EN     = 0;
    localparam int BIT_SINGLE_FAULT_FLAG     = 0;
    localparam int BIT_CMD_START = 0;
    localparam int BIT_CMD_VKEY  = 1;
    localparam int BIT_KEY_LOCK  = 8;
    localparam int SEC_LSB       = 0;
    localparam int BACKDOOR_KEY_ENABLE_LSB     = 6;

    // ------------------------------------------------------------
    // Values and addresses
    // ------------------------------------------------------------
    localparam logic [23:0] ADDR_SEC_BYTE  = 24'hff_fe0f;
    localparam logic [23:0] ADDR_KEY_BASE  = 24'hff_fe00;
    localparam logic [23:0] ADDR_PPROT     = 24'hff_fe0c;
    localparam logic [23:0] ADDR_EPROT     = 24'hff_fe0d;
    localparam logic [23:0] ADDR_OPTION    = 24'hff_fe0e;
    localparam logic [1:0]  SEC_UNSECURED  = 2'h2;
    localparam logic [1:0]  BACKDOOR_KEY_ENABLE_ENABLED  = 2'h2;
    localparam logic [7:0]  DEF_SECURITY   = 8'h00;
    localparam logic [7:0]  DEF_PROTECT    = 8'h00;
    localparam logic [7:0]  DEF_OPTION     = 8'hff;
    localparam logic [15:0] KEY_ZERO       = 16'h0000;
    localparam logic [15:0] KEY_ONES       = 16'hffff;
    localparam int          NUM_KEYS       = 4;
    localparam int          NUM_IRQ        = 2;

    // Init steps: 3 protection/option bytes, security, 4 keys
    localparam int          INIT_HOLD_CYC  = 4;
    localparam int          KEY_CMP_CYC    = 4;

    typedef enum {
        FISI_ST_INIT_HOLD,
        FISI_ST_INIT_LOAD,
        FISI_ST_INIT_KEYS,
        FISI_ST_IDLE,
        FISI_ST_CMD,
        FISI_ST_VKEY
    } fisi_state_e;

endpackage

// File: hdl/fisi_core.sv
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps

// How it works
// - Command interrupt is high while command-complete flag and its enable are set.
// - Error interrupt is high while single-fault flag and its enable are set.
// - Wait mode changes nothing; command interrupt also serves as wakeup.
// - Stop request is acknowledged only once no command is running.
// - Reset sequence loads security register from configuration byte at ff_fe0f.
// - Programmed security byte affects state only after next reset.
// - Key check runs only with keys enabled; compares four 16-bit keys.
// - Full key match forces security state field to unsecured 10.
// - Stored or presented keys 0000 or ffff never match.
// - Flash reads return invalid data while key check runs.
// - A failed key check locks out further key checks until reset.
// - Key check never writes security byte, keys or protection register.
// - Every reset loads configuration, both protections, option and security.
// - Any load error falls back to fully protected, secured defaults.
// - Double-bit fault during reset sets both verify status bits.
// - Complete flag low during init, CPU held early, set at end.
// - Reset aborts any running command immediately.
module fisi_core #(
    parameter int CMD_CYCLES = 16
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Non-volatile array read port for the reset sequence
    output logic             nvm_rd_req,
    output logic      [23:0] nvm_rd_addr,
    input  wire logic [15:0] nvm_rd_data,
    input  wire logic        nvm_rd_dbl_fault,
    // Flash read path toward the CPU
    input  wire logic        cpu_rd_req,
    input  wire logic        cpu_rd_sgl_fault,
    output logic             cpu_rd_invalid,
    output logic             cpu_hold,
    // System modes
    input  wire logic        stop_req,
    output logic             stop_ack,
    output logic             wake_req,
    output logic [1:0]       security_state_field,
    output logic             cmd_irq,
    output logic             err_irq,
    output logic             irq
);

    if (CMD_CYCLES < 1 || CMD_CYCLES > 65535) begin : g_bad_cmd_cycles
        $error("CMD_CYCLES out of range");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fisi_pkg::fisi_state_e state;
    logic [3:0]  step;
    logic [15:0] cnt;
    logic        init_err;
    logic        cmd_complete_flag;
    logic [1:0]  verify_status_bits;
    logic        cmd_complete_irq_en;
    logic        single_fault_irq_en;
    logic        single_fault_flag;
    logic [7:0]  security_reg;
    logic [7:0]  pflash_protect_reg;
    logic [7:0]  eeprom_protect_reg;
    logic [7:0]  option_reg;
    logic [15:0] stored_key [fisi_pkg::NUM_KEYS];
    logic [15:0] user_key   [fisi_pkg::NUM_KEYS];
    logic        key_lock;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_en;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic acc    = psel & penable & pready;
    wire logic wr     = acc & pwrite;
    wire logic idle   = state == fisi_pkg::FISI_ST_IDLE;
    wire logic in_init = state == fisi_pkg::FISI_ST_INIT_HOLD ||
                         state == fisi_pkg::FISI_ST_INIT_LOAD ||
                         state == fisi_pkg::FISI_ST_INIT_KEYS;
    wire logic hit_stat = paddr == fisi_pkg::OFS_STATUS;
    wire logic hit_cfg  = paddr == fisi_pkg::OFS_CONFIG;
    wire logic hit_ecfg = paddr == fisi_pkg::OFS_ERR_CFG;
    wire logic hit_est  = paddr == fisi_pkg::OFS_ERR_STAT;
    wire logic hit_sec  = paddr == fisi_pkg::OFS_SECURITY;
    wire logic hit_pp   = paddr == fisi_pkg::OFS_PPROT;
    wire logic hit_ep   = paddr == fisi_pkg::OFS_EPROT;
    wire logic hit_opt  = paddr == fisi_pkg::OFS_OPTION;
    wire logic hit_cmd  = paddr == fisi_pkg::OFS_CMD;
    wire logic hit_k01  = paddr == fisi_pkg::OFS_KEY01;
    wire logic hit_k23  = paddr == fisi_pkg::OFS_KEY23;
    wire logic hit_ist  = paddr == fisi_pkg::OFS_IRQ_STAT;
    wire logic hit_ien  = paddr == fisi_pkg::OFS_IRQ_EN;
    wire logic hit_icl  = paddr == fisi_pkg::OFS_IRQ_CLR;
    wire logic mapped   = hit_stat | hit_cfg | hit_ecfg | hit_est | hit_sec
                        | hit_pp | hit_ep | hit_opt | hit_cmd | hit_k01
                        | hit_k23 | hit_ist | hit_ien | hit_icl;

    wire logic launch   = wr & hit_cmd & idle &
                          pwdata[fisi_pkg::BIT_CMD_START];
    wire logic backdoor_key_enable_ok = security_reg[fisi_pkg::BACKDOOR_KEY_ENABLE_LSB +: 2] ==
                          fisi_pkg::BACKDOOR_KEY_ENABLE_ENABLED;
    wire logic vkey_ok  = pwdata[fisi_pkg::BIT_CMD_VKEY] & backdoor_key_enable_ok &
                          ~key_lock;
    wire logic key_go   = launch & vkey_ok;
    wire logic cmd_go   = launch & ~pwdata[fisi_pkg::BIT_CMD_VKEY];

    // ------------------------------------------------------------
    // Key comparison
    // ------------------------------------------------------------
    logic [fisi_pkg::NUM_KEYS-1:0] key_hit;
    genvar gk;
    generate
        for (gk = 0; gk < fisi_pkg::NUM_KEYS; gk++) begin : g_key
            assign key_hit[gk] = stored_key[gk] == user_key[gk] &&
                stored_key[gk] != fisi_pkg::KEY_ZERO &&
                stored_key[gk] != fisi_pkg::KEY_ONES;
        end
    endgenerate
    wire logic key_match = &key_hit;
    wire logic cnt_done  = cnt == 16'h0000;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Reset is asynchronous, so a running command stops dead here
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= fisi_pkg::FISI_ST_INIT_HOLD;
            step  <= 4'h0;
            cnt   <= 16'(fisi_pkg::INIT_HOLD_CYC);
        end else begin
            case (state)
                fisi_pkg::FISI_ST_INIT_LOAD: begin
                    step <= step + 4'h1;
                    if (step == 4'h1) begin
                        state <= fisi_pkg::FISI_ST_INIT_KEYS;
                        step  <= 4'h0;
                    end
                end
                fisi_pkg::FISI_ST_INIT_KEYS: begin
                    step <= step + 4'h1;
                    if (step == 4'(fisi_pkg::NUM_KEYS - 1)) begin
                        state <= fisi_pkg::FISI_ST_IDLE;
                    end
                end
                fisi_pkg::FISI_ST_IDLE: begin
                    if (key_go) begin
                        state <= fisi_pkg::FISI_ST_VKEY;
                        cnt   <= 16'(fisi_pkg::KEY_CMP_CYC);
                    end else if (cmd_go) begin
                        state <= fisi_pkg::FISI_ST_CMD;
                        cnt   <= 16'(CMD_CYCLES);
                    end
                end
                default: begin
                    cnt <= cnt - 16'h0001;
                    if (cnt_done && in_init) begin
                        state <= fisi_pkg::FISI_ST_INIT_LOAD;
                    end else if (cnt_done) begin
                        state <= fisi_pkg::FISI_ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_comb begin
        nvm_rd_req  = state == fisi_pkg::FISI_ST_INIT_LOAD ||
                      state == fisi_pkg::FISI_ST_INIT_KEYS;
        nvm_rd_addr = fisi_pkg::ADDR_KEY_BASE;
        if (state == fisi_pkg::FISI_ST_INIT_LOAD) begin
            nvm_rd_addr = step[0] ? fisi_pkg::ADDR_OPTION
                                  : fisi_pkg::ADDR_PPROT;
        end else if (state == fisi_pkg::FISI_ST_INIT_KEYS) begin
            nvm_rd_addr = fisi_pkg::ADDR_KEY_BASE + {19'h0, step[1:0], 1'b0};
        end
    end

    wire logic ld_prot = state == fisi_pkg::FISI_ST_INIT_LOAD && !step[0];
    wire logic ld_sec  = state == fisi_pkg::FISI_ST_INIT_LOAD && step[0];
    wire logic ld_key  = state == fisi_pkg::FISI_ST_INIT_KEYS;
    wire logic init_end = ld_key && step == 4'(fisi_pkg::NUM_KEYS - 1);
    wire logic err_any = init_err | nvm_rd_dbl_fault;

    // ------------------------------------------------------------
    // Loaded configuration
    // ------------------------------------------------------------
    // Security only loads here, so a newly programmed byte waits for reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pflash_protect_reg <= fisi_pkg::DEF_PROTECT;
            eeprom_protect_reg <= fisi_pkg::DEF_PROTECT;
            option_reg         <= fisi_pkg::DEF_OPTION;
            security_reg       <= fisi_pkg::DEF_SECURITY;
            init_err           <= 1'b0;
        end else begin
            init_err <= init_err | (nvm_rd_req & nvm_rd_dbl_fault);
            if (ld_prot) begin
                pflash_protect_reg <= nvm_rd_data[15:8];
                eeprom_protect_reg <= nvm_rd_data[7:0];
            end
            if (ld_sec) begin
                option_reg   <= nvm_rd_data[15:8];
                security_reg <= nvm_rd_data[7:0];
            end
            if (init_end && err_any) begin
                pflash_protect_reg <= fisi_pkg::DEF_PROTECT;
                eeprom_protect_reg <= fisi_pkg::DEF_PROTECT;
                option_reg         <= fisi_pkg::DEF_OPTION;
                security_reg       <= fisi_pkg::DEF_SECURITY;
            end
            // Only the two state bits move; stored byte untouched
            if (state == fisi_pkg::FISI_ST_VKEY && cnt_done && key_match) begin
                security_reg[fisi_pkg::SEC_LSB +: 2] <=
                    fisi_pkg::SEC_UNSECURED;
            end
        end
    end

    genvar gs;
    generate
        for (gs = 0; gs < fisi_pkg::NUM_KEYS; gs++) begin : g_store
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    stored_key[gs] <= fisi_pkg::KEY_ONES;
                    user_key[gs]   <= fisi_pkg::KEY_ZERO;
                end else begin
                    if (ld_key && step[1:0] == 2'(gs)) begin
                        stored_key[gs] <= nvm_rd_data;
                    end
                    if (wr && idle && (gs < 2 ? hit_k01 : hit_k23)) begin
                        user_key[gs] <= pwdata[16*(gs%2) +: 16];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    wire logic sfault_set = cpu_rd_req & cpu_rd_sgl_fault & ~in_init;
    wire logic sfault_clr = wr & hit_est & pwdata[fisi_pkg::BIT_SINGLE_FAULT_FLAG];
    wire logic vkey_fail  = state == fisi_pkg::FISI_ST_VKEY && cnt_done &&
                            !key_match;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmd_complete_flag   <= 1'b0;
            verify_status_bits  <= 2'h0;
            cmd_complete_irq_en <= 1'b0;
            single_fault_irq_en <= 1'b0;
            single_fault_flag   <= 1'b0;
            key_lock            <= 1'b0;
        end else begin
            if (init_end) begin
                cmd_complete_flag <= 1'b1;
            end else if (key_go || cmd_go) begin
                cmd_complete_flag <= 1'b0;
            end else if (!idle && !in_init && cnt_done) begin
                cmd_complete_flag <= 1'b1;
            end
            if (init_end && err_any) begin
                verify_status_bits <= 2'h3;
            end else if (cmd_go || key_go) begin
                verify_status_bits <= 2'h0;
            end
            if (vkey_fail) begin
                key_lock <= 1'b1;
            end
            if (sfault_set) begin
                single_fault_flag <= 1'b1;
            end else if (sfault_clr) begin
                single_fault_flag <= 1'b0;
            end
            if (wr && hit_cfg) begin
                cmd_complete_irq_en <= pwdata[fisi_pkg::BIT_CMD_COMPLETE_IRQ_EN];
            end
            if (wr && hit_ecfg) begin
                single_fault_irq_en <= pwdata[fisi_pkg::BIT_SINGLE_FAULT_IRQ_EN];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    wire logic [1:0] irq_evt = {sfault_set, init_end | (!idle && !in_init
                                && cnt_done)};
    wire logic [1:0] irq_clr = (wr && hit_icl) ? pwdata[1:0] : 2'h0;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_stat <= 2'h0;
            irq_en   <= 2'h0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
            if (wr && hit_ien) begin
                irq_en <= pwdata[1:0];
            end
        end
    end

    assign cmd_irq  = cmd_complete_flag & cmd_complete_irq_en;
    assign err_irq  = single_fault_flag & single_fault_irq_en;
    assign irq      = |(irq_stat & irq_en);
    assign wake_req = cmd_irq;
    assign stop_ack = stop_req & idle;
    assign cpu_hold = state == fisi_pkg::FISI_ST_INIT_HOLD;
    assign cpu_rd_invalid = state == fisi_pkg::FISI_ST_VKEY;
    assign security_state_field = security_reg[fisi_pkg::SEC_LSB +: 2];

    // ------------------------------------------------------------
    // APB read and answer
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_stat) begin
            rd_mux = {24'h0, cmd_complete_flag, 5'h0, verify_status_bits};
        end else if (hit_cfg) begin
            rd_mux = {24'h0, cmd_complete_irq_en, 7'h0};
        end else if (hit_ecfg) begin
            rd_mux = {31'h0, single_fault_irq_en};
        end else if (hit_est) begin
            rd_mux = {31'h0, single_fault_flag};
        end else if (hit_sec) begin
            rd_mux = {24'h0, security_reg};
        end else if (hit_pp) begin
            rd_mux = {24'h0, pflash_protect_reg};
        end else if (hit_ep) begin
            rd_mux = {24'h0, eeprom_protect_reg};
        end else if (hit_opt) begin
            rd_mux = {24'h0, option_reg};
        end else if (hit_cmd) begin
            rd_mux = {23'h0, key_lock, 6'h0, state == fisi_pkg::FISI_ST_VKEY,
                      !idle};
        end else if (hit_ist) begin
            rd_mux = {30'h0, irq_stat};
        end else if (hit_ien) begin
            rd_mux = {30'h0, irq_en};
        end
    end

    // CPU stalled by the init hold: the APB answer waits too
    assign pready  = ~cpu_hold;
    assign pslverr = acc & ~mapped;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

endmodule

// File: test/fisi_chk.sv
`timescale 1ns/1ps
// ------
// Port checker
// ------
module fisi_chk (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       pready,
    input wire logic       cpu_hold,
    input wire logic       cpu_rd_invalid,
    input wire logic       stop_req,
    input wire logic       stop_ack,
    input wire logic       wake_req,
    input wire logic       nvm_rd_req,
    input wire logic [1:0] security_state_field,
    input wire logic       cmd_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Saturating age since reset; keeps the init checks cheap
    logic [3:0] age;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) age <= 4'h0;
        else if (age != 4'hf) age <= age + 4'h1;
    end
    property p_hold_early; age < 4'h4 |-> cpu_hold && !pready; endproperty
    a_hold_early: assert property (p_hold_early)
        else $error("cpu access released too early");
    property p_hold_end; age >= 4'h8 |-> !cpu_hold; endproperty
    a_hold_end: assert property (p_hold_end)
        else $error("cpu hold not removed");
    property p_flag_init; age < 4'h9 |-> !cmd_irq; endproperty
    a_flag_init: assert property (p_flag_init)
        else $error("complete flag set during init");
    property p_wake; wake_req == cmd_irq; endproperty
    a_wake: assert property (p_wake)
        else $error("wakeup does not follow command irq");
    property p_stop;
        stop_ack |-> stop_req && !cpu_rd_invalid && !nvm_rd_req;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop granted while busy");
    property p_inv_len;
        $rose(cpu_rd_invalid) |-> cpu_rd_invalid[*2] ##[1:7] !cpu_rd_invalid;
    endproperty
    a_inv_len: assert property (p_inv_len)
        else $error("invalid read window has wrong length");
    property p_inv_nohold; cpu_rd_invalid |-> !cpu_hold && !nvm_rd_req;
    endproperty
    a_inv_nohold: assert property (p_inv_nohold)
        else $error("key check overlaps init");
    property p_sec;
        $changed(security_state_field) && !$past(nvm_rd_req)
            && !$past(nvm_rd_req, 2) |-> security_state_field == 2'h2;
    endproperty
    a_sec: assert property (p_sec)
        else $error("security changed outside load or unlock");
endmodule
bind fisi_core fisi_chk u_chk (.clk_sys, .rst, .pready, .cpu_hold,
    .cpu_rd_invalid, .stop_req, .stop_ack, .wake_req, .nvm_rd_req,
    .security_state_field, .cmd_irq);

// File: test/fisi_nvm.sv
`timescale 1ns/1ps
// ------
// Configuration field of the array, read only
// ------
module fisi_nvm (
    input  wire logic        nvm_rd_req,
    input  wire logic [23:0] nvm_rd_addr,
    input  wire logic        fault_en,
    input  wire logic [7:0]  sec_byte,
    input  wire logic [63:0] keys,
    output logic      [15:0] nvm_rd_data,
    output logic             nvm_rd_dbl_fault
);
    logic [15:0] word;
    always_comb begin
        case (nvm_rd_addr)
            24'hff_fe0c: word = 16'h3cc3;
            24'hff_fe0e: word = {8'h5a, sec_byte};
            24'hff_fe00: word = keys[15:0];
            24'hff_fe02: word = keys[31:16];
            24'hff_fe04: word = keys[47:32];
            24'hff_fe06: word = keys[63:48];
            default:     word = 16'h0000;
        endcase
    end
    // Unselected reads show inverted data, so a stale capture is caught
    assign nvm_rd_data      = nvm_rd_req ? word : ~word;
    assign nvm_rd_dbl_fault = nvm_rd_req & fault_en;
endmodule

// File: test/test_flash_irq_security_init.sv
`timescale 1ns/1ps
module test_flash_irq_security_init;
    typedef struct {logic [11:0] a; logic [31:0] x; logic e;} fisi_row_s;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, nvm_rd_req, nvm_rd_dbl_fault, e;
    logic [23:0] nvm_rd_addr;
    logic [15:0] nvm_rd_data;
    logic cpu_rd_req = 0, cpu_rd_sgl_fault = 0, stop_req = 0, fault_en = 0;
    logic cpu_rd_invalid, cpu_hold, stop_ack, wake_req, cmd_irq, err_irq, irq;
    logic [1:0]  security_state_field;
    logic [7:0]  sec_byte = 8'h81;
    logic [63:0] keys = 64'h4444_3333_2222_1111;
    int miscompares = 0, n_compared = 0, cyc = 0;
    fisi_row_s rows [6] = '{
        '{12'h000, 32'h80, 1'b0},
        '{12'h010, 32'h81, 1'b0},
        '{12'h014, 32'h3c, 1'b0},
        '{12'h018, 32'hc3, 1'b0},
        '{12'h01c, 32'h5a, 1'b0},
        '{12'h040, 32'h00, 1'b1}};
    always #4 clk_sys = ~clk_sys;
    fisi_core #(.CMD_CYCLES(8)) DUT (.clk_sys, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .nvm_rd_req,
        .nvm_rd_addr, .nvm_rd_data, .nvm_rd_dbl_fault, .cpu_rd_req,
        .cpu_rd_sgl_fault, .cpu_rd_invalid, .cpu_hold, .stop_req, .stop_ack,
        .wake_req, .security_state_field, .cmd_irq, .err_irq, .irq);
    fisi_nvm u_nvm (.nvm_rd_req, .nvm_rd_addr, .fault_en, .sec_byte, .keys,
        .nvm_rd_data, .nvm_rd_dbl_fault);
    // ------
    // Tasks
    // ------
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys) penable <= 1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk_sys);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d); apb(1, a, d);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 0);
        chk("read", x, r);
    endtask
    task wait_done;
        for (int i = 0; i < 40 && cmd_irq !== 1'b1; i++) @(posedge clk_sys);
    endtask
    task keycheck(input logic [31:0] k01, input logic [31:0] k23);
        wr(12'h024, k01); wr(12'h028, k23); wr(12'h020, 32'h3);
    endtask
    task do_reset;
        rst <= 1;
        repeat (16) @(posedge clk_sys);
        rst <= 0;
        repeat (16) @(posedge clk_sys);
        wr(12'h004, 32'h80);
    endtask
    task print_verdict;
        $display("Compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            print_verdict();
        end
    end
    // ------
    // Sequence
    // ------
    initial begin
        do_reset();
        foreach (rows[i]) begin
            apb(0, rows[i].a, 0);
            chk("row data", rows[i].x, r);
            chk("row error", rows[i].e, e);
        end
        $display("Test rows done");
        stop_req <= 1;
        @(posedge clk_sys);
        chk("cmd irq", 1, cmd_irq);
        chk("wake", 1, wake_req);
        chk("stop idle", 1, stop_ack);
        wr(12'h030, 32'h1);
        wr(12'h034, 32'h1);
        wr(12'h020, 32'h1);
        chk("irq busy", 0, irq);
        chk("cmd irq busy", 0, cmd_irq);
        chk("stop busy", 0, stop_ack);
        wait_done();
        chk("stop done", 1, stop_ack);
        chk("irq", 1, irq);
        wr(12'h030, 32'h0);
        chk("irq masked", 0, irq);
        wr(12'h030, 32'h1); wr(12'h034, 32'h1);
        chk("irq cleared", 0, irq);
        stop_req <= 0;
        $display("Test command irq done");
        wr(12'h008, 32'h1);
        cpu_rd_req <= 1; cpu_rd_sgl_fault <= 1;
        @(posedge clk_sys) {cpu_rd_req, cpu_rd_sgl_fault} <= 2'b00;
        @(posedge clk_sys);
        chk("err irq", 1, err_irq);
        wr(12'h00c, 32'h1);
        chk("err irq cleared", 0, err_irq);
        $display("Test fault irq done");
        keycheck(32'h2222_1112, 32'h4444_3333);
        chk("reads invalid", 1, cpu_rd_invalid);
        wait_done();
        keycheck(32'h2222_1111, 32'h4444_3333);
        wait_done();
        chk("locked", 1, security_state_field);
        rdc(12'h020, 32'h100);
        sec_byte <= 8'h83;
        wr(12'h020, 32'h1);
        chk("byte pending", 1, security_state_field);
        do_reset();
        chk("byte loaded", 3, security_state_field);
        rdc(12'h020, 32'h0);
        keycheck(32'h2222_1111, 32'h4444_3333);
        wait_done();
        chk("unsecured", 2, security_state_field);
        rdc(12'h010, 32'h82);
        rdc(12'h014, 32'h3c);
        $display("Test keys done");
        keys <= 64'h4444_3333_2222_0000;
        do_reset();
        keycheck(32'h2222_0000, 32'h4444_3333);
        wait_done();
        chk("zero key", 3, security_state_field);
        fault_en <= 1;
        do_reset();
        rdc(12'h000, 32'h83);
        rdc(12'h010, 32'h00);
        rdc(12'h014, 32'h00);
        rdc(12'h01c, 32'hff);
        $display("Test init faults done");
        print_verdict();
    end
endmodule
